// *** core/cfel_event_logic.sv ***
// Function event, mask, force and wake-up gating with AHB-Lite slave.
//
// Functional notes
// - Interrupt event bit sets while the interrupt source is high, mask aside.
// - Interrupt event bit clears on write-one only once the source is idle.
// - Writing zero to event bit 15 or bit 4 leaves it unchanged.
// - Wake-up event bit sets while the wake-up source is high, mask aside.
// - Write-one to wake-up event bit clears it and PME status.
// - Write-one to PME status also clears the wake-up event bit.
// - Gate bit 15 at zero blocks the interrupt output only.
// - Interrupt gate effect also depends on gate bit 4.
// - Gate bit 14 at zero blocks wake-up output unless PME enable is set, events untouched.
// - Gate bit 4 at zero blocks wake-up to status-change output unless PME enable is set.
// - Status-change asserts if wake-up gates both set, or PME enable.
// - Force bit 15 write-one sets interrupt event bit.
// - Force bit 4 write-one sets wake-up event bit.
`timescale 1ns/1ps
`include "cfel_defines.svh"

module cfel_event_logic
   import cfel_pkg::*;
(
   input  wire logic        sys_clk_i,   // Bus clock, 100 MHz.
   input  wire logic        rst_i,       // Synchronous reset, active high.
   input  wire logic        hsel_i,      // AHB slave select.
   input  wire logic [31:0] haddr_i,     // AHB address.
   input  wire logic [1:0]  htrans_i,    // AHB transfer type.
   input  wire logic        hwrite_i,    // AHB write strobe.
   input  wire logic [2:0]  hsize_i,     // AHB transfer size.
   input  wire logic [31:0] hwdata_i,    // AHB write data.
   input  wire logic        hready_i,    // AHB bus ready.
   output logic [31:0]      hrdata_o,    // AHB read data.
   output logic             hreadyout_o, // AHB slave ready.
   output logic             hresp_o,     // AHB response, always OKAY.
   input  wire logic        eth_int_i,   // Ethernet interrupt source.
   input  wire logic        eth_wake_i,  // Ethernet wake-up source.
   output logic             inta_o,      // Card interrupt line, high active.
   output logic             stschg_o,    // Status-change signal.
   output logic             irq_o        // Local interrupt output.
);

   // ----------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------
   cfel_req_t   req_q;
   cfel_state_t state_q;
   logic        take;
   logic        wr_ph;
   logic        rd_ph;
   logic [31:0] wd;

   // An access is taken while the bus is ready and the transfer is real.
   assign take  = hsel_i & hready_i & htrans_i[1];
   assign wr_ph = (state_q == CFEL_DATA) & req_q.wr;
   assign rd_ph = (state_q == CFEL_DATA) & ~req_q.wr;
   assign wd    = hwdata_i;

   // Address phase capture; hsize is ignored since only words are used.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         state_q <= CFEL_IDLE;
         req_q   <= '0;
      end
      else if (take)
      begin
         state_q <= CFEL_DATA;
         req_q   <= '{wr: hwrite_i, addr: haddr_i[11:0]};
      end
      else
      begin
         state_q <= CFEL_IDLE;
      end
   end

   // Zero wait states; the slave never stalls, so ready is constant high.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
      else
      begin
         hreadyout_o <= 1'b1;
         hresp_o     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Decoded write strobes
   // ----------------------------------------------------------------------
   logic wr_flags;
   logic wr_gate;
   logic wr_force;
   logic wr_pm;
   logic wr_imask;
   logic rd_istat;

   assign wr_flags = wr_ph & (req_q.addr == `CFEL_OFS_FLAGS);
   assign wr_gate  = wr_ph & (req_q.addr == `CFEL_OFS_GATE);
   assign wr_force = wr_ph & (req_q.addr == `CFEL_OFS_FORCE);
   assign wr_pm    = wr_ph & (req_q.addr == `CFEL_OFS_PM);
   assign wr_imask = wr_ph & (req_q.addr == `CFEL_OFS_IRQ_MASK);
   assign rd_istat = rd_ph & (req_q.addr == `CFEL_OFS_IRQ_STAT);

   // ----------------------------------------------------------------------
   // Event flags
   // ----------------------------------------------------------------------
   logic int_ev_q;
   logic gwu_ev_q;
   logic pme_st_q;
   logic pme_en_q;
   logic force_int;
   logic force_wake;
   logic clr_gwu;

   assign force_int  = wr_force & wd[`CFEL_BIT_INT];
   assign force_wake = wr_force & wd[`CFEL_BIT_GWU];
   // Either clear path acts on both wake-up status bits.
   assign clr_gwu = (wr_flags & wd[`CFEL_BIT_GWU])
                  | (wr_pm & wd[`CFEL_BIT_PME_ST]);

   // Interrupt event: the source and the force win over any clear, and a
   // clear is refused while the source is still pending.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         int_ev_q <= 1'b0;
      else if (eth_int_i | force_int)
         int_ev_q <= 1'b1;
      else if (wr_flags & wd[`CFEL_BIT_INT])
         int_ev_q <= 1'b0;
   end

   // Wake-up event: set beats clear so no wake-up is lost.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         gwu_ev_q <= 1'b0;
      else if (eth_wake_i | force_wake)
         gwu_ev_q <= 1'b1;
      else if (clr_gwu)
         gwu_ev_q <= 1'b0;
   end

   // PME status follows wake-up events; PME enable is plain read/write.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         pme_st_q <= 1'b0;
         pme_en_q <= 1'b0;
      end
      else
      begin
         if (eth_wake_i | force_wake)
            pme_st_q <= 1'b1;
         else if (clr_gwu)
            pme_st_q <= 1'b0;
         if (wr_pm)
            pme_en_q <= wd[`CFEL_BIT_PME_EN];
      end
   end

   // ----------------------------------------------------------------------
   // Gate register
   // ----------------------------------------------------------------------
   // Reset image of the gate word, so each stored bit takes its own bit.
   localparam logic [31:0] GATE_RST = `CFEL_RST_GATE;

   logic gate_int_q;
   logic gate_wake_q;
   logic gate_gwu_q;

   // Only bits 15, 14 and 4 are stored; the rest are not kept at all.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         gate_int_q  <= GATE_RST[`CFEL_BIT_INT];
         gate_wake_q <= GATE_RST[`CFEL_BIT_WAKE];
         gate_gwu_q  <= GATE_RST[`CFEL_BIT_GWU];
      end
      else if (wr_gate)
      begin
         gate_int_q  <= wd[`CFEL_BIT_INT];
         gate_wake_q <= wd[`CFEL_BIT_WAKE];
         gate_gwu_q  <= wd[`CFEL_BIT_GWU];
      end
   end

   // ----------------------------------------------------------------------
   // Output gating
   // ----------------------------------------------------------------------
   logic int_out;
   logic wake_out;

   // The interrupt gate is qualified by the general wake-up gate: with
   // bit 4 set the line is reserved for wake-up signalling, so the
   // interrupt needs bit 15 set and bit 4 clear to reach the line.
   assign int_out  = int_ev_q & gate_int_q & ~gate_gwu_q;
   assign wake_out = gwu_ev_q & ((gate_wake_q & gate_gwu_q)
                   | pme_en_q);

   // Registered pin drivers keep outputs glitch-free.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         inta_o   <= 1'b0;
         stschg_o <= 1'b0;
      end
      else
      begin
         inta_o   <= int_out;
         stschg_o <= wake_out;
      end
   end

   // ----------------------------------------------------------------------
   // Local interrupt status and mask
   // ----------------------------------------------------------------------
   logic [1:0] istat_q;
   logic [1:0] imask_q;
   logic [1:0] ev_set;

   // Every wake-up or interrupt event sets its sticky bit, the first too.
   assign ev_set = {eth_wake_i | force_wake,
                    eth_int_i | force_int};

   // Sticky bits cleared by a read; a new event in that cycle still sets.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         istat_q <= 2'h0;
      else
         istat_q <= ev_set | (rd_istat ? 2'h0 : istat_q);
   end

   // Mask register, same layout as the status.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         imask_q <= 2'h0;
      else if (wr_imask)
         imask_q <= wd[1:0];
   end

   // Level interrupt from the next status value, with new events and the read clear, and the mask.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         irq_o <= 1'b0;
      else
         irq_o <= |((ev_set | (rd_istat ? 2'h0 : istat_q)) & imask_q);
   end

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   logic [31:0] rdata;

   // Unmapped and write-only addresses read as zero.
   always_comb
   begin
      rdata = 32'h0000_0000;
      if (take & ~hwrite_i)
      begin
         unique case (haddr_i[11:0])
            `CFEL_OFS_FLAGS:
            begin
               rdata[`CFEL_BIT_INT] = int_ev_q;
               rdata[`CFEL_BIT_GWU] = gwu_ev_q;
            end
            `CFEL_OFS_GATE:
            begin
               rdata[`CFEL_BIT_INT] = gate_int_q;
               rdata[`CFEL_BIT_WAKE] = gate_wake_q;
               rdata[`CFEL_BIT_GWU] = gate_gwu_q;
            end
            `CFEL_OFS_PM:
            begin
               rdata[`CFEL_BIT_PME_ST] = pme_st_q;
               rdata[`CFEL_BIT_PME_EN] = pme_en_q;
            end
            `CFEL_OFS_IRQ_STAT: rdata[1:0] = ev_set | istat_q;
            `CFEL_OFS_IRQ_MASK: rdata[1:0] = imask_q;
            default:            rdata = 32'h0000_0000;
         endcase
      end
   end

   // Read data is registered at the address-phase edge for the data phase.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         hrdata_o <= 32'h0000_0000;
      else
         hrdata_o <= rdata;
   end

endmodule

// *** core/cfel_defines.svh ***
// Register offsets, field positions and reset values of the event block.
`ifndef CFEL_DEFINES_SVH
`define CFEL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define CFEL_OFS_FLAGS      12'h100
`define CFEL_OFS_GATE       12'h104
`define CFEL_OFS_FORCE      12'h10c
`define CFEL_OFS_PM         12'h110
`define CFEL_OFS_IRQ_STAT   12'h114
`define CFEL_OFS_IRQ_MASK   12'h118

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CFEL_BIT_INT        15
`define CFEL_BIT_WAKE       14
`define CFEL_BIT_GWU        4
`define CFEL_BIT_PME_EN     8
`define CFEL_BIT_PME_ST     15
`define CFEL_IRQ_INT        0
`define CFEL_IRQ_WAKE       1

// ----------------------------------------------------------------------
// Reset values and address width
// ----------------------------------------------------------------------
`define CFEL_RST_FLAGS      32'h0000_0000
`define CFEL_RST_GATE       32'h0000_8000
`define CFEL_ADDR_W         12

`endif

// *** core/cfel_pkg.sv ***
// Types shared by the function event block.
package cfel_pkg;

   // AHB-Lite address phase captured for the data phase.
   typedef struct packed
   {
      logic        wr;
      logic [11:0] addr;
   } cfel_req_t;

   // Slave data phase state.
   typedef enum logic [0:0] {CFEL_IDLE, CFEL_DATA} cfel_state_t;

endpackage

// *** tb/cfel_properties.sv ***
// Port-level assertions for the function event block.
`timescale 1ns/1ps
`include "cfel_defines.svh"

module cfel_properties
   import cfel_pkg::*;
(
   input wire logic        sys_clk_i,   // Clock.
   input wire logic        rst_i,       // Reset.
   input wire logic        hsel_i,      // Select.
   input wire logic [31:0] haddr_i,     // Address.
   input wire logic [1:0]  htrans_i,    // Transfer.
   input wire logic        hwrite_i,    // Write.
   input wire logic [31:0] hwdata_i,    // Write data.
   input wire logic        hready_i,    // Ready in.
   input wire logic [31:0] hrdata_o,    // Read data.
   input wire logic        hreadyout_o, // Ready out.
   input wire logic        hresp_o,     // Response.
   input wire logic        eth_int_i,   // Int source.
   input wire logic        eth_wake_i,  // Wake source.
   input wire logic        inta_o,      // Card line.
   input wire logic        stschg_o,    // Status change.
   input wire logic        irq_o        // Local irq.
);
   // ------------
   // Shadow state
   // ------------
   logic        take;
   logic        wp_q;
   logic        rd_q;
   logic [11:0] wa_q;
   logic [31:0] gate_q;
   logic        pme_q;
   logic [1:0]  msk_q;
   logic        int_ok;
   logic        wake_ok;

   assign take = hsel_i & hready_i & htrans_i[1];
   assign int_ok = gate_q[15] & ~gate_q[4];
   assign wake_ok = gate_q[14] & gate_q[4];

   // Shadows follow finished writes, so no internals are needed.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         wp_q   <= 1'b0;
         rd_q   <= 1'b0;
         wa_q   <= 12'h000;
         gate_q <= `CFEL_RST_GATE;
         pme_q  <= 1'b0;
         msk_q  <= 2'h0;
      end
      else
      begin
         wp_q <= take & hwrite_i;
         rd_q <= take & ~hwrite_i;
         wa_q <= haddr_i[11:0];
         if (wp_q && wa_q == `CFEL_OFS_GATE)
            gate_q <= hwdata_i;
         if (wp_q && wa_q == `CFEL_OFS_PM)
            pme_q <= hwdata_i[8];
         if (wp_q && wa_q == `CFEL_OFS_IRQ_MASK)
            msk_q <= hwdata_i[1:0];
      end
   end

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   a_resp_okay: assert property (hreadyout_o && !hresp_o)
      else $error("slave not ready or not okay");
   a_rdata_idle: assert property (!rd_q |-> hrdata_o == 32'h0)
      else $error("read data outside a read");
   a_int_raises: assert property (
      eth_int_i && int_ok ##1 int_ok |=> inta_o)
      else $error("interrupt source did not reach card line");
   a_inta_gated: assert property (inta_o |-> $past(int_ok))
      else $error("card line high while gated");
   a_wake_raises: assert property (
      eth_wake_i && wake_ok ##1 wake_ok |=> stschg_o)
      else $error("wake-up did not reach status change");
   a_stschg_gated: assert property (
      stschg_o |-> $past(wake_ok | pme_q))
      else $error("status change while gated");
   a_irq_masked: assert property (irq_o |->
      $past(msk_q) != 2'h0 || $past(msk_q, 2) != 2'h0)
      else $error("local irq while masked");
   a_quiet_after_reset: assert property (
      $fell(rst_i) |-> !inta_o && !stschg_o && !irq_o)
      else $error("outputs active after reset");

   c_inta: cover property ($rose(inta_o));
   c_stschg: cover property ($rose(stschg_o));
   c_irq: cover property ($rose(irq_o));
endmodule

bind cfel_event_logic cfel_properties cfel_properties_i
(
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
   .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .eth_int_i(eth_int_i), .eth_wake_i(eth_wake_i), .inta_o(inta_o),
   .stschg_o(stschg_o), .irq_o(irq_o)
);

// *** tb/cfel_eth_model.sv ***
// Behavioural model of the Ethernet event sources.
`timescale 1ns/1ps

module cfel_eth_model
   import cfel_pkg::*;
(
   input  wire logic sys_clk_i,    // Clock.
   input  wire logic raise_int_i,  // Start a pending cause.
   input  wire logic service_i,    // Cause serviced.
   input  wire logic raise_wake_i, // One wake-up event.
   output logic      eth_int_o,    // Interrupt level.
   output logic      eth_wake_o    // Wake-up pulse.
);
   // A cause stays pending until serviced, as a real one does.
   always_ff @(posedge sys_clk_i)
   begin
      if (service_i)
         eth_int_o <= 1'b0;
      else if (raise_int_i)
         eth_int_o <= 1'b1;
   end

   // A wake-up is one cycle long, so the block has to latch it.
   always_ff @(posedge sys_clk_i)
      eth_wake_o <= raise_wake_i;
endmodule

// *** tb/cardbus_function_event_logic_tb_top.sv ***
// Self-checking bench for the function event block.
`timescale 1ns/1ps
`include "cfel_defines.svh"

module cardbus_function_event_logic_tb_top
   import cfel_pkg::*;
   ;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        r_int = 1'b0;
   logic        r_wake = 1'b0;
   logic        svc = 1'b1;
   logic [31:0] hrdata;
   logic        hready;
   logic        hresp;
   logic        eth_int;
   logic        eth_wake;
   logic        inta;
   logic        stschg;
   logic        irq;
   logic        rd_ph = 1'b0;
   logic [31:0] exp_q[$];
   int          mismatches = 0;
   int          checked = 0;

   always #5 clk = ~clk;

   cfel_event_logic cfel_event_logic_i
   (
      .sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .eth_int_i(eth_int),
      .eth_wake_i(eth_wake), .inta_o(inta), .stschg_o(stschg),
      .irq_o(irq)
   );

   cfel_eth_model cfel_eth_model_i
   (
      .sys_clk_i(clk), .raise_int_i(r_int), .service_i(svc),
      .raise_wake_i(r_wake), .eth_int_o(eth_int), .eth_wake_o(eth_wake)
   );

   // ---------------
   // Tasks
   // ---------------
   task automatic chk(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic pin(input string nm, input logic s, e);
      chk(nm, {31'h0, s}, {31'h0, e});
   endtask

   // Address phase is held until ready is seen, then the data phase.
   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge clk);
      while (hready !== 1'b1)
         @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1)
         @(posedge clk);
   endtask

   // One idle cycle after a write; a read at once would already see the new data.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      @(posedge clk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, $urandom);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic close_out;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Read results are compared as each read data phase ends.
   always @(posedge clk)
   begin
      if (rd_ph)
         chk("read data", hrdata, exp_q.pop_front());
      rd_ph = hsel & htrans[1] & ~hwrite & hready;
   end

   initial
   begin
      #100000;
      mismatches++;
      close_out;
   end

   // ---------------
   // Main sequence
   // ---------------
   initial
   begin
      void'($urandom(32'hc85b));
      idle(3);
      rst <= 1'b0;
      svc <= 1'b0;
      idle(1);
      rd(`CFEL_OFS_FLAGS, `CFEL_RST_FLAGS);
      rd(`CFEL_OFS_GATE, `CFEL_RST_GATE);
      wr(`CFEL_OFS_FLAGS, 32'hffffffff);
      rd(`CFEL_OFS_FLAGS, 32'h0);
      wr(`CFEL_OFS_GATE, $urandom | 32'hc010);
      rd(`CFEL_OFS_GATE, 32'hc010);
      wr(12'h1f0, $urandom);
      rd(12'h1f0, 32'h0);
      $display("test registers done");
      wr(`CFEL_OFS_GATE, 32'h8000);
      r_int <= 1'b1;
      idle(1);
      r_int <= 1'b0;
      idle(3);
      rd(`CFEL_OFS_FLAGS, 32'h8000);
      pin("inta", inta, 1'b1);
      wr(`CFEL_OFS_FLAGS, 32'h8000);
      rd(`CFEL_OFS_FLAGS, 32'h8000);
      idle($urandom_range(6, 2));
      svc <= 1'b1;
      idle(1);
      svc <= 1'b0;
      idle(2);
      wr(`CFEL_OFS_FLAGS, 32'h0);
      rd(`CFEL_OFS_FLAGS, 32'h8000);
      wr(`CFEL_OFS_GATE, 32'h0);
      idle(2);
      pin("inta", inta, 1'b0);
      wr(`CFEL_OFS_GATE, 32'h8010);
      idle(2);
      pin("inta", inta, 1'b0);
      wr(`CFEL_OFS_FLAGS, 32'h8000);
      rd(`CFEL_OFS_FLAGS, 32'h0);
      $display("test interrupt done");
      wr(`CFEL_OFS_GATE, 32'h4010);
      wr(`CFEL_OFS_FORCE, 32'h10);
      idle(2);
      pin("stschg", stschg, 1'b1);
      wr(`CFEL_OFS_FORCE, 32'h8000);
      rd(`CFEL_OFS_FLAGS, 32'h8010);
      rd(`CFEL_OFS_FORCE, 32'h0);
      wr(`CFEL_OFS_FLAGS, 32'h8010);
      rd(`CFEL_OFS_FLAGS, 32'h0);
      r_wake <= 1'b1;
      idle(1);
      r_wake <= 1'b0;
      idle(3);
      rd(`CFEL_OFS_FLAGS, 32'h10);
      rd(`CFEL_OFS_PM, 32'h8000);
      wr(`CFEL_OFS_GATE, 32'h4000);
      idle(2);
      pin("stschg", stschg, 1'b0);
      wr(`CFEL_OFS_GATE, 32'h0010);
      idle(2);
      pin("stschg", stschg, 1'b0);
      wr(`CFEL_OFS_PM, 32'h0100);
      idle(2);
      pin("stschg", stschg, 1'b1);
      wr(`CFEL_OFS_FLAGS, 32'h10);
      rd(`CFEL_OFS_FLAGS, 32'h0);
      rd(`CFEL_OFS_PM, 32'h100);
      r_wake <= 1'b1;
      idle(1);
      r_wake <= 1'b0;
      idle(3);
      wr(`CFEL_OFS_PM, 32'h8000);
      rd(`CFEL_OFS_FLAGS, 32'h0);
      $display("test wake-up done");
      rd(`CFEL_OFS_IRQ_STAT, 32'h3);
      wr(`CFEL_OFS_IRQ_MASK, 32'h3);
      wr(`CFEL_OFS_FORCE, 32'h8000);
      idle(3);
      pin("irq", irq, 1'b1);
      rd(`CFEL_OFS_IRQ_STAT, 32'h1);
      idle(3);
      pin("irq", irq, 1'b0);
      wr(`CFEL_OFS_IRQ_MASK, 32'h0);
      wr(`CFEL_OFS_FORCE, 32'h8000);
      idle(3);
      pin("irq", irq, 1'b0);
      rd(`CFEL_OFS_IRQ_STAT, 32'h1);
      idle(2);
      $display("test irq done");
      close_out;
   end
endmodule
